// ===== inc/spi_slave_pkg.sv
// package for the spi slave port and its master end
// assumes: both ends run from one 50 MHz system clock
package spi_slave_pkg;
	// register map
	localparam logic [7:0] addr_slave_config = 8'hbc;
	localparam logic [7:0] addr_slave_event_flags = 8'hbe;
	localparam logic [7:0] addr_slave_data_port = 8'hbf;
	// configuration fields
	localparam int cfg_slave_core_on = 0;
	localparam int cfg_sample_edge_select = 1;
	localparam int cfg_sck_idle_level = 2;
	localparam int cfg_bit_sequence_select = 3;
	localparam int cfg_mask_xfer_done_irq = 4;
	localparam int cfg_mask_select_fall_irq = 5;
	localparam int cfg_mask_select_rise_irq = 6;
	localparam logic [6:0] cfg_reset = 7'h70;
	// event flag fields
	localparam int evt_xfer_done_flag = 0;
	localparam int evt_select_fall_seen = 4;
	localparam int evt_select_rise_seen = 5;
	localparam logic [5:0] evt_reset = 6'h00;
	localparam logic [7:0] data_reset = 8'h00;
	// master controller registers
	localparam logic [7:0] addr_host_control = 8'h00;
	localparam logic [7:0] addr_host_tx = 8'h01;
	localparam logic [7:0] addr_host_rx = 8'h02;
	localparam logic [7:0] addr_host_status = 8'h03;
	localparam logic [7:0] addr_host_mask = 8'h04;
	localparam logic [7:0] addr_host_divider = 8'h05;
	localparam int hctl_polarity = 0;
	localparam int hctl_phase = 1;
	localparam int hctl_lsb_first = 2;
	localparam int hctl_select = 3;
	localparam logic [7:0] host_divider_reset = 8'h04;
	localparam int clk_sys_mhz = 50;
	localparam int bits_per_byte = 8;
endpackage

// ===== inc/spi_link_if.sv
// serial link between spi slave port and external spi master
// assumes: the master end resolves the slave-out wire from its enable
`timescale 1ns/1ns
`default_nettype none
interface spi_link_if;
	logic slave_select_n;
	logic slave_serial_clock;
	logic slave_data_in;
	logic slave_data_out;
	logic slave_data_out_oe_n;
	modport device (
		input slave_select_n,
		input slave_serial_clock,
		input slave_data_in,
		output slave_data_out,
		output slave_data_out_oe_n
	);
	modport master (
		output slave_select_n,
		output slave_serial_clock,
		output slave_data_in,
		input slave_data_out,
		input slave_data_out_oe_n
	);
endinterface
`default_nettype wire

// ===== hdl/spi_slave_port.sv
// spi slave port: configuration, event flags, data port, serial core
// assumes: link pins are asynchronous to clk_sys, sampled by two flops
//
// Chosen here: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module spi_slave_port
	import spi_slave_pkg::*;
(
	input wire logic clk_sys, // system clock
	input wire logic rst, // async reset, high
	spi_link_if.device link, // serial pins
	input wire logic [7:0] reg_addr, // register address
	input wire logic [7:0] reg_wdata, // write data
	input wire logic reg_write, // write strobe
	input wire logic reg_read, // read strobe
	output logic [7:0] reg_rdata, // read data, cycle after read
	output logic irq // level interrupt
);
	typedef struct packed {
		logic [2:0] sel_sync;
		logic [2:0] sck_sync;
		logic [1:0] din_sync;
		logic [6:0] cfg;
		logic [5:0] evt;
		logic [7:0] rx_data;
		logic [7:0] tx_shift;
		logic [7:0] tx_wait;
		logic tx_wait_full;
		logic tx_spent;
		logic [7:0] rx_shift;
		logic [2:0] bit_cnt;
		logic dout;
		logic [7:0] rdata;
	} state_t;
	state_t cur, nxt;

	// ********************************************************************
	// helpers
	// ********************************************************************
	function automatic logic out_bit(input logic [7:0] b, input logic lsb);
		out_bit = lsb ? b[0] : b[7];
	endfunction

	function automatic logic [7:0] shift_on(input logic [7:0] b, input logic lsb);
		shift_on = lsb ? {1'b0, b[7:1]} : {b[6:0], 1'b0};
	endfunction

	// ********************************************************************
	// next state
	// ********************************************************************
	logic sel_n, sck_prev, sck_now, sel_prev, en, lsb, lead, trail, sample, shift;
	logic sel_fall, sel_rise;
	logic [5:0] events;
	always_comb
	begin
		nxt = cur;
		nxt.sel_sync = {cur.sel_sync[1:0], link.slave_select_n};
		nxt.sck_sync = {cur.sck_sync[1:0], link.slave_serial_clock};
		nxt.din_sync = {cur.din_sync[0], link.slave_data_in};
		sel_n = cur.sel_sync[1];
		sel_prev = cur.sel_sync[2];
		sck_now = cur.sck_sync[1];
		sck_prev = cur.sck_sync[2];
		en = cur.cfg[cfg_slave_core_on];
		lsb = cur.cfg[cfg_bit_sequence_select];
		// leading edge leaves the idle level
		lead = (sck_now != sck_prev) && (sck_prev == cur.cfg[cfg_sck_idle_level]);
		trail = (sck_now != sck_prev) && (sck_prev != cur.cfg[cfg_sck_idle_level]);
		sample = cur.cfg[cfg_sample_edge_select] ? trail : lead;
		shift = cur.cfg[cfg_sample_edge_select] ? lead : trail;
		sel_fall = en && sel_prev && !sel_n;
		sel_rise = en && !sel_prev && sel_n;
		events = '0;
		events[evt_select_rise_seen] = sel_rise;
		events[evt_select_fall_seen] = sel_fall;
		nxt.rdata = 8'h00;
		// read clears, a same-cycle event still sets
		if (reg_read)
		begin
			unique case (reg_addr)
				addr_slave_config: nxt.rdata = {1'b0, cur.cfg};
				addr_slave_event_flags:
				begin
					nxt.rdata = {2'b00, cur.evt};
					nxt.evt = evt_reset;
				end
				addr_slave_data_port: nxt.rdata = cur.rx_data;
				default: nxt.rdata = 8'h00;
			endcase
		end
		if (reg_write && reg_addr == addr_slave_config)
			nxt.cfg = reg_wdata[6:0];
		if (reg_write && reg_addr == addr_slave_data_port)
		begin
			if (sel_n && !cur.tx_wait_full)
			begin
				// while deselected only the shifted byte can be preloaded
				nxt.tx_shift = reg_wdata;
				nxt.dout = out_bit(reg_wdata, lsb);
			end
			else if (!sel_n && cur.tx_spent)
			begin
				// chain ran dry at byte end: refill the shifter itself
				nxt.tx_shift = reg_wdata;
				nxt.dout = out_bit(reg_wdata, lsb);
				nxt.tx_spent = 1'b0;
			end
			else if (!sel_n)
			begin
				nxt.tx_wait = reg_wdata;
				nxt.tx_wait_full = 1'b1;
			end
		end
		// the core is frozen while disabled
		if (en)
		begin
			if (sel_fall)
			begin
				nxt.bit_cnt = 3'd0;
				nxt.tx_spent = 1'b0;
				nxt.dout = out_bit(cur.tx_shift, lsb);
			end
			else if (!sel_n)
			begin
				if (sample)
				begin
					nxt.rx_shift = lsb ? {cur.din_sync[1], cur.rx_shift[7:1]}
						: {cur.rx_shift[6:0], cur.din_sync[1]};
					nxt.bit_cnt = cur.bit_cnt + 3'd1;
					if (cur.bit_cnt == 3'd7)
					begin
						nxt.rx_data = lsb ? {cur.din_sync[1], cur.rx_shift[7:1]}
							: {cur.rx_shift[6:0], cur.din_sync[1]};
						events[evt_xfer_done_flag] = 1'b1;
						if (cur.tx_wait_full)
						begin
							nxt.tx_shift = cur.tx_wait;
							nxt.tx_wait_full = 1'b0;
						end
						else
							nxt.tx_spent = 1'b1;
					end
				end
				if (shift && cur.bit_cnt != 3'd0)
				begin
					// phase 0 puts the first bit out at select fall, later bits on trail
					nxt.tx_shift = shift_on(cur.tx_shift, lsb);
					nxt.dout = out_bit(shift_on(cur.tx_shift, lsb), lsb);
				end
				else if (shift && cur.bit_cnt == 3'd0)
				begin
					nxt.tx_shift = (cur.tx_shift);
					nxt.dout = out_bit(cur.tx_shift, lsb);
				end
			end
		end
		nxt.evt = nxt.evt | events;
	end

	// ********************************************************************
	// registers
	// ********************************************************************
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			cur <= '0;
			cur.sel_sync <= 3'b111;
			cur.cfg <= cfg_reset;
			cur.evt <= evt_reset;
			cur.rx_data <= data_reset;
		end
		else
			cur <= nxt;
	end

	// ********************************************************************
	// outputs
	// ********************************************************************
	assign reg_rdata = cur.rdata;
	assign irq = (cur.evt[evt_select_rise_seen] && !cur.cfg[cfg_mask_select_rise_irq])
		|| (cur.evt[evt_select_fall_seen] && !cur.cfg[cfg_mask_select_fall_irq])
		|| (cur.evt[evt_xfer_done_flag] && !cur.cfg[cfg_mask_xfer_done_irq]);
	assign link.slave_data_out = cur.dout;
	assign link.slave_data_out_oe_n = cur.sel_sync[1] || !cur.cfg[cfg_slave_core_on];
endmodule // spi_slave_port
`default_nettype wire

// ===== hdl/spi_master_end.sv
// external spi master: drives select, clock and data in, reads data out
// assumes: slave-out level arrives asynchronously; link clock from divider
`timescale 1ns/1ns
`default_nettype none
module spi_master_end
	import spi_slave_pkg::*;
(
	input wire logic clk_sys, // system clock
	input wire logic rst, // async reset, high
	spi_link_if.master link, // serial pins
	input wire logic [7:0] reg_addr, // register address
	input wire logic [7:0] reg_wdata, // write data
	input wire logic reg_write, // write strobe
	input wire logic reg_read, // read strobe
	output logic [7:0] reg_rdata, // read data, cycle after read
	output logic irq // level interrupt, byte done
);
	typedef enum logic [1:0] {idle, first_half, second_half} phase_t;
	typedef struct packed {
		phase_t st;
		logic [3:0] ctl;
		logic [7:0] divider;
		logic [7:0] div_cnt;
		logic [7:0] tx;
		logic tx_full;
		logic [7:0] shift;
		logic [2:0] bit_cnt;
		logic [7:0] rx;
		logic [1:0] miso_sync;
		logic sck;
		logic mosi;
		logic done;
		logic mask;
		logic [7:0] rdata;
	} state_t;
	state_t cur, nxt;
	logic lsb, tick, miso;

	// ********************************************************************
	// next state
	// ********************************************************************
	always_comb
	begin
		nxt = cur;
		lsb = cur.ctl[hctl_lsb_first];
		miso = cur.miso_sync[1];
		// a released slave-out line reads high through its pull-up
		nxt.miso_sync = {cur.miso_sync[0], link.slave_data_out_oe_n ? 1'b1 : link.slave_data_out};
		tick = cur.div_cnt == 8'h00;
		nxt.div_cnt = tick ? cur.divider : cur.div_cnt - 8'd1;
		nxt.rdata = 8'h00;
		if (reg_read)
		begin
			unique case (reg_addr)
				addr_host_control: nxt.rdata = {4'h0, cur.ctl};
				addr_host_rx: nxt.rdata = cur.rx;
				addr_host_status:
				begin
					nxt.rdata = {5'h00, cur.st != idle, cur.tx_full, cur.done};
					nxt.done = 1'b0;
				end
				addr_host_mask: nxt.rdata = {7'h00, cur.mask};
				addr_host_divider: nxt.rdata = cur.divider;
				default: nxt.rdata = 8'h00;
			endcase
		end
		if (reg_write)
		begin
			unique case (reg_addr)
				addr_host_control: nxt.ctl = reg_wdata[3:0];
				addr_host_tx:
				begin
					nxt.tx = reg_wdata;
					nxt.tx_full = 1'b1;
				end
				addr_host_mask: nxt.mask = reg_wdata[0];
				addr_host_divider: nxt.divider = (reg_wdata == 8'h00) ? 8'h01 : reg_wdata;
				default: ;
			endcase
		end
		if (cur.st == idle)
			nxt.sck = cur.ctl[hctl_polarity];
		if (tick)
		begin
			unique case (cur.st)
				idle:
					if (cur.tx_full && cur.ctl[hctl_select])
					begin
						nxt.shift = cur.tx;
						nxt.tx_full = 1'b0;
						nxt.bit_cnt = 3'd0;
						nxt.mosi = out_first(cur.tx, lsb);
						nxt.st = first_half;
					end
				first_half:
				begin
					// leading edge
					nxt.sck = !cur.sck;
					nxt.st = second_half;
					if (cur.ctl[hctl_phase])
						nxt.mosi = out_first(cur.shift, lsb);
					else
						nxt.shift = take(cur.shift, miso, lsb);
				end
				second_half:
				begin
					// trailing edge
					nxt.sck = !cur.sck;
					if (cur.ctl[hctl_phase])
						nxt.shift = take(cur.shift, miso, lsb);
					nxt.bit_cnt = cur.bit_cnt + 3'd1;
					nxt.st = first_half;
					if (cur.bit_cnt == 3'd7)
					begin
						nxt.rx = cur.ctl[hctl_phase] ? take(cur.shift, miso, lsb) : cur.shift;
						nxt.done = 1'b1;
						nxt.st = idle;
					end
					else if (!cur.ctl[hctl_phase])
						nxt.mosi = out_first(cur.shift, lsb);
				end
				default: nxt.st = idle;
			endcase
		end
	end

	// shift in a sampled bit and move the next outgoing bit to the edge
	function automatic logic [7:0] take(input logic [7:0] b, input logic d, input logic l);
		take = l ? {d, b[7:1]} : {b[6:0], d};
	endfunction

	function automatic logic out_first(input logic [7:0] b, input logic l);
		out_first = l ? b[0] : b[7];
	endfunction

	// ********************************************************************
	// registers
	// ********************************************************************
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			cur <= '0;
			cur.st <= idle;
			cur.divider <= host_divider_reset;
			cur.mask <= 1'b1;
		end
		else
			cur <= nxt;
	end

	assign reg_rdata = cur.rdata;
	assign irq = cur.done && !cur.mask;
	assign link.slave_select_n = !cur.ctl[hctl_select];
	assign link.slave_serial_clock = cur.sck;
	assign link.slave_data_in = cur.mosi;
endmodule // spi_master_end
`default_nettype wire

// ===== bench/spi_slave_port_checker.sv
// link checker: watches the serial pins between master end and slave port
// assumes: link signals seen on clk_sys, reset active high
`timescale 1ns/1ns
`default_nettype none
module spi_slave_port_checker
(
	input wire logic clk_sys, // system clock
	input wire logic rst, // async reset, high
	input wire logic slave_select_n, // select, low active
	input wire logic slave_serial_clock, // link clock
	input wire logic slave_data_in, // master to slave
	input wire logic slave_data_out, // slave to master
	input wire logic slave_data_out_oe_n // slave drive enable, low
);
	// ****************************************
	// link assertions
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// selected with no clock edge for long enough to settle any shift
	sequence link_quiet;
		(!slave_select_n && $stable(slave_serial_clock))[*8];
	endsequence
	sequence deselected;
		slave_select_n[*6];
	endsequence
	oe_idle_a: assert property (deselected |-> slave_data_out_oe_n)
		else $error("slave drives output while deselected");
	oe_release_a: assert property ($rose(slave_select_n) |-> ##[0:5] slave_data_out_oe_n)
		else $error("slave output not released after deselect");
	miso_steady_a: assert property (link_quiet |-> $stable(slave_data_out))
		else $error("slave output moved without a shift edge");
	sck_select_a: assert property ($fell(slave_select_n) |-> $stable(slave_serial_clock)[*4])
		else $error("link clock moved at select fall");
	sequence sck_moved;
		$changed(slave_serial_clock);
	endsequence
	sck_half_a: assert property (sck_moved |=> $stable(slave_serial_clock)[*5])
		else $error("link clock half period too short");
	mosi_hold_a: assert property (deselected |-> $stable(slave_data_in))
		else $error("master data moved while deselected");
endmodule // spi_slave_port_checker
`default_nettype wire

// ===== bench/spi_slave_port_test.sv
// self-checking bench: slave port and master end joined by the link
// assumes: 50 MHz clk_sys, master divider makes the link clock
`timescale 1ns/1ns
`default_nettype none
module spi_slave_port_test
	import spi_slave_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr [2] = '{default: 8'h00};
	logic [7:0] wdata [2] = '{default: 8'h00};
	logic wr [2] = '{default: 1'b0};
	logic rd [2] = '{default: 1'b0};
	logic [7:0] rdata [2];
	logic irq [2];
	logic pol = 1'b0;
	logic ph = 1'b0;
	logic [7:0] mo_q = 8'h00;
	logic [7:0] mi_q = 8'h00;
	int bad_count = 0;
	int num_checks = 0;
	int nbits = 0;
	int cycles = 0;
	spi_link_if link();
	spi_slave_port u_spi_slave_port (.clk_sys(clk_sys), .rst(rst), .link(link),
		.reg_addr(addr[0]), .reg_wdata(wdata[0]), .reg_write(wr[0]), .reg_read(rd[0]),
		.reg_rdata(rdata[0]), .irq(irq[0]));
	spi_master_end u_spi_master_end (.clk_sys(clk_sys), .rst(rst), .link(link),
		.reg_addr(addr[1]), .reg_wdata(wdata[1]), .reg_write(wr[1]), .reg_read(rd[1]),
		.reg_rdata(rdata[1]), .irq(irq[1]));
	spi_slave_port_checker u_spi_slave_port_checker (.clk_sys(clk_sys), .rst(rst),
		.slave_select_n(link.slave_select_n), .slave_serial_clock(link.slave_serial_clock),
		.slave_data_in(link.slave_data_in), .slave_data_out(link.slave_data_out),
		.slave_data_out_oe_n(link.slave_data_out_oe_n));
	initial forever #10 clk_sys = ~clk_sys;
	// ****************************************
	// tasks
	// ****************************************
	task chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		num_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task bus_wr(input int s, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		addr[s] <= a;
		wdata[s] <= d;
		wr[s] <= 1'b1;
		@(posedge clk_sys);
		wr[s] <= 1'b0;
	endtask
	task bus_rd(input int s, input logic [7:0] a, output logic [7:0] v);
		@(posedge clk_sys);
		addr[s] <= a;
		rd[s] <= 1'b1;
		@(posedge clk_sys);
		rd[s] <= 1'b0;
		#1 v = rdata[s];
	endtask
	task rd_chk(input int s, input logic [7:0] a, input logic [7:0] exp, input string what);
		logic [7:0] v;
		bus_rd(s, a, v);
		chk(v, exp, what);
	endtask
	// waits for the master byte-done interrupt, then clears it
	task wait_done;
		logic [7:0] v;
		for (int n = 0; n < 2000 && irq[1] !== 1'b1; n++)
			@(posedge clk_sys);
		chk({7'h00, irq[1]}, 8'h01, "master done");
		bus_rd(1, addr_host_status, v);
	endtask
	task wrap_up;
		if (bad_count == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge clk_sys)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			bad_count++;
			wrap_up();
		end
	end
	// captures both data lines at each sample edge of the current mode
	always @(link.slave_serial_clock)
		if (!link.slave_select_n && (link.slave_serial_clock ^ pol ^ ph))
		begin
			mo_q = {mo_q[6:0], link.slave_data_in};
			mi_q = {mi_q[6:0], link.slave_data_out};
			nbits++;
		end
	// ****************************************
	// stimulus
	// ****************************************
	initial
	begin
		logic [7:0] s1, s2, m1, m2, cfg, w_in, w_out;
		logic lsb;
		logic [2:0] msk;
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		rd_chk(0, addr_slave_config, 8'h70, "cfg reset");
		rd_chk(0, addr_slave_event_flags, 8'h00, "flags reset");
		rd_chk(0, addr_slave_data_port, 8'h00, "data reset");
		chk({7'h00, irq[0]}, 8'h00, "irq reset");
		chk({7'h00, link.slave_data_out_oe_n}, 8'h01, "oe reset");
		bus_wr(0, 8'hbd, 8'hff);
		bus_wr(0, addr_slave_event_flags, 8'hff);
		rd_chk(0, 8'hbd, 8'h00, "unmapped");
		rd_chk(0, addr_slave_event_flags, 8'h00, "flags ro");
		bus_wr(1, addr_host_mask, 8'h00);
		bus_wr(1, addr_host_divider, 8'h07);
		for (int i = 0; i < 4; i++)
		begin
			pol = i[1];
			ph = i[0];
			lsb = i[0] ^ i[1];
			msk = {3{i[0]}};
			s1 = 8'hc5 ^ 8'(i);
			s2 = 8'h1e ^ 8'(i);
			m1 = 8'h96 ^ 8'(i);
			m2 = 8'h2b ^ 8'(i);
			cfg = {1'b0, msk, lsb, pol, ph, 1'b1};
			bus_wr(0, addr_slave_config, cfg);
			rd_chk(0, addr_slave_config, cfg, "cfg");
			bus_wr(1, addr_host_control, {5'h00, lsb, ph, pol});
			repeat (4) @(posedge clk_sys);
			chk({7'h00, link.slave_serial_clock}, {7'h00, pol}, "sck idle");
			bus_wr(0, addr_slave_data_port, 8'hee);
			bus_wr(0, addr_slave_data_port, s1);
			nbits = 0;
			bus_wr(1, addr_host_control, {4'h0, 1'b1, lsb, ph, pol});
			// the second preload must wait until the slave has seen select low
			repeat (4) @(posedge clk_sys);
			if (!i[0])
				bus_wr(0, addr_slave_data_port, s2);
			bus_wr(1, addr_host_tx, m1);
			wait_done();
			chk({7'h00, link.slave_data_out_oe_n}, 8'h00, "oe on");
			rd_chk(1, addr_host_rx, s1, "first out");
			if (i[0])
				bus_wr(0, addr_slave_data_port, s2);
			bus_wr(1, addr_host_tx, m2);
			wait_done();
			rd_chk(1, addr_host_rx, s2, "second out");
			// done flag needs the link synchroniser, some 3 cycles
			repeat (8) @(posedge clk_sys);
			chk({7'h00, irq[0]}, {7'h00, ~i[0]}, "irq frame");
			rd_chk(0, addr_slave_event_flags, 8'h11, "flags frame");
			rd_chk(0, addr_slave_data_port, m2, "rx byte");
			chk({7'h00, irq[0]}, 8'h00, "irq clear");
			chk(8'(nbits), 8'h10, "bit count");
			w_in = m2;
			w_out = s2;
			if (lsb)
			begin
				w_in = {<<{m2}};
				w_out = {<<{s2}};
			end
			chk(mo_q, w_in, "in wire");
			chk(mi_q, w_out, "out wire");
			bus_wr(1, addr_host_control, {5'h00, lsb, ph, pol});
			repeat (8) @(posedge clk_sys);
			chk({7'h00, irq[0]}, {7'h00, ~i[0]}, "irq rise");
			rd_chk(0, addr_slave_event_flags, 8'h20, "flags rise");
			rd_chk(0, addr_slave_event_flags, 8'h00, "flags clear");
		end
		pol = 1'b0;
		ph = 1'b0;
		bus_wr(0, addr_slave_config, 8'h00);
		// settle the clock idle level before select falls
		bus_wr(1, addr_host_control, 8'h00);
		bus_wr(1, addr_host_control, 8'h08);
		bus_wr(1, addr_host_tx, 8'h5a);
		wait_done();
		chk({7'h00, link.slave_data_out_oe_n}, 8'h01, "oe off");
		rd_chk(1, addr_host_rx, 8'hff, "rx released");
		bus_wr(1, addr_host_control, 8'h00);
		repeat (8) @(posedge clk_sys);
		rd_chk(0, addr_slave_event_flags, 8'h00, "flags off");
		chk({7'h00, irq[0]}, 8'h00, "irq off");
		wrap_up();
	end
endmodule // spi_slave_port_test
`default_nettype wire
